// ---- common/sfc_consts.vh ----
`ifndef SFC_CONSTS_VH
`define SFC_CONSTS_VH

// ----------------------------------------
// Register map (word index on the plain port)
// ----------------------------------------
`define SFC_ADDR_W          4
`define SFC_DATA_W          16
`define SFC_REG_STATUS      4'h0
`define SFC_REG_MASK        4'h1
`define SFC_REG_LEVEL       4'h2

// ----------------------------------------
// Status and mask bit positions
// ----------------------------------------
`define SFC_EV_W            4
`define SFC_EV_OVERFLOW     0
`define SFC_EV_UNDERFLOW    1
`define SFC_EV_ALMOST_FULL  2
`define SFC_EV_ALMOST_EMPTY 3

// ----------------------------------------
// Level register fields
// ----------------------------------------
`define SFC_LEVEL_MODE_BIT  15

// ----------------------------------------
// Offset register file and default offsets
// ----------------------------------------
`define SFC_OFS_EMPTY_LO    2'h0
`define SFC_OFS_EMPTY_HI    2'h1
`define SFC_OFS_FULL_LO     2'h2
`define SFC_OFS_FULL_HI     2'h3
`define SFC_OFS_DEFAULT     16'h0007
`define SFC_OFS_LO_RESET    8'h07
`define SFC_OFS_HI_RESET    8'h00

// ----------------------------------------
// Dual-purpose pin modes
// ----------------------------------------
`define SFC_MODE_LOAD       1'b0
`define SFC_MODE_SECOND_WE  1'b1

`endif

// ---- core/sfc_ram.v ----
`default_nettype none

// ----------------------------------------
// Storage array, one write port, async read
// ----------------------------------------
module sfc_ram #(
	parameter WIDTH  = 9,
	parameter ADDR_W = 6
) (
	input  wire              clk,
	input  wire              we,
	input  wire [ADDR_W-1:0] waddr,
	input  wire [WIDTH-1:0]  wdata,
	input  wire [ADDR_W-1:0] raddr,
	output wire [WIDTH-1:0]  rdata
);
	reg [WIDTH-1:0] mem [0:(1<<ADDR_W)-1];

	// No reset: contents are don't-care until written
	always @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	// Read mux; the caller registers the word
	assign rdata = mem[raddr];
endmodule

`default_nettype wire

// ---- core/sfc_fifo.v ----
// The address-and-strobe port and the address map were chosen for this implementation.
`include "sfc_consts.vh"
`default_nettype none

module sfc_fifo #(
	parameter WIDTH  = 9,
	parameter ADDR_W = 6
) (
	input  wire                   clk,
	input  wire                   rst_b,
	input  wire                   master_reset_n,
	input  wire [WIDTH-1:0]       wr_data,
	input  wire                   primary_write_gate_n,
	input  wire                   second_write_gate_or_offset_load,
	input  wire                   primary_read_gate_n,
	input  wire                   secondary_read_gate_n,
	output reg  [WIDTH-1:0]       rd_data,
	output reg                    empty_indicator_n,
	output reg                    full_indicator_n,
	output reg                    almost_empty_indicator_n,
	output reg                    almost_full_indicator_n,
	input  wire [`SFC_ADDR_W-1:0] reg_addr,
	input  wire [`SFC_DATA_W-1:0] reg_wdata,
	input  wire                   reg_wr,
	input  wire                   reg_rd,
	output reg  [`SFC_DATA_W-1:0] reg_rdata,
	output wire                   irq
);
	localparam [ADDR_W:0] DEPTH = {1'b1, {ADDR_W{1'b0}}};

	reg                    mode_reg;
	reg  [7:0]             ofs_reg [0:3];
	reg  [1:0]             ld_wsel_reg;
	reg  [1:0]             ld_rsel_reg;
	reg  [ADDR_W-1:0]      wptr_reg;
	reg  [ADDR_W-1:0]      rptr_reg;
	reg  [ADDR_W:0]        count_reg;
	reg  [ADDR_W:0]        count_next;
	reg  [`SFC_EV_W-1:0]   status_reg;
	reg  [`SFC_EV_W-1:0]   mask_reg;
	reg  [`SFC_EV_W-1:0]   events;
	wire [WIDTH-1:0]       ram_rdata;
	wire                   load_sel;
	wire                   wr_req;
	wire                   rd_req;
	wire                   do_wr;
	wire                   do_rd;
	wire                   ld_wr;
	wire                   ld_rd;
	wire [15:0]            empty_ofs;
	wire [15:0]            full_ofs;
	wire [16:0]            count_ext;
	wire                   ae_low_next;
	wire                   af_low_next;

	// ----------------------------------------
	// Access decode
	// ----------------------------------------
	// Load selection only exists in load mode with the pin low
	assign load_sel = (mode_reg == `SFC_MODE_LOAD) && !second_write_gate_or_offset_load;
	// both write gates needed
	// Pin high is also the normal-write level in load mode, so one term serves both
	assign wr_req   = !primary_write_gate_n && second_write_gate_or_offset_load;
	assign rd_req   = !primary_read_gate_n && !secondary_read_gate_n;
	assign do_wr    = wr_req && full_indicator_n && master_reset_n;
	assign do_rd    = rd_req && !load_sel && empty_indicator_n && master_reset_n;
	// load write when primary gate active
	assign ld_wr    = load_sel && !primary_write_gate_n && master_reset_n;
	assign ld_rd    = load_sel && rd_req && master_reset_n;

	// ----------------------------------------
	// Mode capture
	// ----------------------------------------
	// sample pin only while reset held
	// low selects load, high selects second write gate
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			mode_reg <= `SFC_MODE_LOAD;
		end else if (!master_reset_n) begin
			mode_reg <= second_write_gate_or_offset_load;
		end
	end

	// ----------------------------------------
	// Offset registers and load sequencers
	// ----------------------------------------
	// Only the low byte of each data word is loaded; bit 8 is ignored
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ofs_reg[0]  <= `SFC_OFS_LO_RESET;
			ofs_reg[1]  <= `SFC_OFS_HI_RESET;
			ofs_reg[2]  <= `SFC_OFS_LO_RESET;
			ofs_reg[3]  <= `SFC_OFS_HI_RESET;
			ld_wsel_reg <= 2'h0;
			ld_rsel_reg <= 2'h0;
		end else if (!master_reset_n) begin
			ofs_reg[0]  <= `SFC_OFS_LO_RESET;
			ofs_reg[1]  <= `SFC_OFS_HI_RESET;
			ofs_reg[2]  <= `SFC_OFS_LO_RESET;
			ofs_reg[3]  <= `SFC_OFS_HI_RESET;
			ld_wsel_reg <= 2'h0;
			ld_rsel_reg <= 2'h0;
		end else begin
			if (ld_wr) begin
				ofs_reg[ld_wsel_reg] <= wr_data[7:0];
				ld_wsel_reg          <= ld_wsel_reg + 2'h1;
			end
			if (ld_rd) begin
				ld_rsel_reg <= ld_rsel_reg + 2'h1;
			end
		end
	end

	assign empty_ofs = (mode_reg == `SFC_MODE_SECOND_WE) ? `SFC_OFS_DEFAULT :
		{ofs_reg[`SFC_OFS_EMPTY_HI], ofs_reg[`SFC_OFS_EMPTY_LO]};
	assign full_ofs  = (mode_reg == `SFC_MODE_SECOND_WE) ? `SFC_OFS_DEFAULT :
		{ofs_reg[`SFC_OFS_FULL_HI], ofs_reg[`SFC_OFS_FULL_LO]};

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	sfc_ram #(
		.WIDTH  (WIDTH),
		.ADDR_W (ADDR_W)
	) u_ram (
		.clk   (clk),
		.we    (do_wr),
		.waddr (wptr_reg),
		.wdata (wr_data),
		.raddr (rptr_reg),
		.rdata (ram_rdata)
	);

	// ----------------------------------------
	// Pointers, level and flags
	// ----------------------------------------
	// Next level from this cycle's accepted accesses
	always @* begin
		count_next = count_reg;
		if (do_wr && !do_rd) begin
			count_next = count_reg + {{ADDR_W{1'b0}}, 1'b1};
		end else if (do_rd && !do_wr) begin
			count_next = count_reg - {{ADDR_W{1'b0}}, 1'b1};
		end
	end

	assign count_ext   = {{(16-ADDR_W){1'b0}}, count_next};
	// low while level at most offset
	assign ae_low_next = count_ext <= {1'b0, empty_ofs};
	assign af_low_next = (count_ext + {1'b0, full_ofs}) >= {{(16-ADDR_W){1'b0}}, DEPTH};

	// Flags come from the next level, so they agree with the level one edge on.
	// single clock, flag moves on the edge after the access
	// read at the rising edge leaving offset words drives almost empty low
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wptr_reg                 <= {ADDR_W{1'b0}};
			rptr_reg                 <= {ADDR_W{1'b0}};
			count_reg                <= {(ADDR_W+1){1'b0}};
			empty_indicator_n        <= 1'b0;
			full_indicator_n         <= 1'b1;
			almost_empty_indicator_n <= 1'b0;
			almost_full_indicator_n  <= 1'b1;
		end else if (!master_reset_n) begin
			wptr_reg                 <= {ADDR_W{1'b0}};
			rptr_reg                 <= {ADDR_W{1'b0}};
			count_reg                <= {(ADDR_W+1){1'b0}};
			empty_indicator_n        <= 1'b0;
			full_indicator_n         <= 1'b1;
			almost_empty_indicator_n <= 1'b0;
			almost_full_indicator_n  <= 1'b1;
		end else begin
			if (do_wr) begin
				wptr_reg <= wptr_reg + {{(ADDR_W-1){1'b0}}, 1'b1};
			end
			if (do_rd) begin
				rptr_reg <= rptr_reg + {{(ADDR_W-1){1'b0}}, 1'b1};
			end
			count_reg                <= count_next;
			empty_indicator_n        <= (count_next != {(ADDR_W+1){1'b0}});
			full_indicator_n         <= (count_next != DEPTH);
			almost_empty_indicator_n <= !ae_low_next;
			almost_full_indicator_n  <= !af_low_next;
		end
	end

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	// Output holds its last word when no read is taken
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rd_data <= {WIDTH{1'b0}};
		end else if (!master_reset_n) begin
			rd_data <= {WIDTH{1'b0}};
		end else if (ld_rd) begin
			rd_data <= {{(WIDTH-8){1'b0}}, ofs_reg[ld_rsel_reg]};
		end else if (do_rd) begin
			rd_data <= ram_rdata;
		end
	end

	// ----------------------------------------
	// Events, status, mask and register port
	// ----------------------------------------
	always @* begin
		events                        = {`SFC_EV_W{1'b0}};
		events[`SFC_EV_OVERFLOW]      = wr_req && !full_indicator_n && master_reset_n;
		events[`SFC_EV_UNDERFLOW]     = rd_req && !load_sel && !empty_indicator_n
			&& master_reset_n;
		events[`SFC_EV_ALMOST_FULL]   = master_reset_n && af_low_next
			&& almost_full_indicator_n;
		events[`SFC_EV_ALMOST_EMPTY]  = master_reset_n && ae_low_next
			&& almost_empty_indicator_n;
	end

	// Set wins over a same-cycle write-one-to-clear, so no event is lost
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			status_reg <= {`SFC_EV_W{1'b0}};
			mask_reg   <= {`SFC_EV_W{1'b0}};
			reg_rdata  <= {`SFC_DATA_W{1'b0}};
		end else begin
			if (reg_wr && reg_addr == `SFC_REG_STATUS) begin
				status_reg <= (status_reg & ~reg_wdata[`SFC_EV_W-1:0]) | events;
			end else begin
				status_reg <= status_reg | events;
			end
			if (reg_wr && reg_addr == `SFC_REG_MASK) begin
				mask_reg <= reg_wdata[`SFC_EV_W-1:0];
			end
			// Unmapped addresses read zero
			reg_rdata <= {`SFC_DATA_W{1'b0}};
			if (reg_rd) begin
				case (reg_addr)
				`SFC_REG_STATUS: begin
					reg_rdata <= {{(`SFC_DATA_W-`SFC_EV_W){1'b0}}, status_reg};
				end
				`SFC_REG_MASK: begin
					reg_rdata <= {{(`SFC_DATA_W-`SFC_EV_W){1'b0}}, mask_reg};
				end
				`SFC_REG_LEVEL: begin
					reg_rdata <= {mode_reg, {(`SFC_DATA_W-2-ADDR_W){1'b0}}, count_reg};
				end
				default: begin
					reg_rdata <= {`SFC_DATA_W{1'b0}};
				end
				endcase
			end
		end
	end

	// Level interrupt while any unmasked status bit stands
	assign irq = |(status_reg & mask_reg);
endmodule

`default_nettype wire

// ---- verification/sfc_fifo_assertions.sv ----
`include "sfc_consts.vh"
`default_nettype none
// ----------------------------------------
// Port checker for the FIFO block
// ----------------------------------------
module sfc_fifo_assertions #(parameter WIDTH = 9) (
	input wire logic                   clk,
	input wire logic                   rst_b,
	input wire logic                   master_reset_n,
	input wire logic                   primary_write_gate_n,
	input wire logic                   second_write_gate_or_offset_load,
	input wire logic                   primary_read_gate_n,
	input wire logic [WIDTH-1:0]       rd_data,
	input wire logic                   empty_indicator_n,
	input wire logic                   full_indicator_n,
	input wire logic                   almost_empty_indicator_n,
	input wire logic                   almost_full_indicator_n,
	input wire logic                   reg_rd,
	input wire logic [`SFC_DATA_W-1:0] reg_rdata,
	input wire logic                   irq
);
	timeunit 1ns;
	timeprecision 1ps;
	logic mode_q;
	wire  pin = second_write_gate_or_offset_load;
	wire  mr = master_reset_n;
	wire  wr_t = !primary_write_gate_n && pin;
	wire  w8 = mr && wr_t && primary_read_gate_n;
	wire  [3:0] flags = {empty_indicator_n, full_indicator_n,
		almost_empty_indicator_n, almost_full_indicator_n};
	// Mirror of the pin mode, needed to know when offsets are fixed
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			mode_q <= `SFC_MODE_LOAD;
		else if (!mr)
			mode_q <= pin;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	gate_block_a: assert property (
		mode_q && mr && !pin && primary_read_gate_n |=> $stable(flags))
		else $error("flags moved while a write gate was shut");
	first_word_a: assert property (
		mr && !empty_indicator_n && wr_t |=> empty_indicator_n)
		else $error("write into empty left empty flag low");
	full_hold_a: assert property (
		mr && !full_indicator_n && primary_read_gate_n |=> !full_indicator_n
		&& !almost_full_indicator_n) else $error("full state left without a read");
	empty_hold_a: assert property (
		mr && !empty_indicator_n && primary_write_gate_n && pin
		|=> !empty_indicator_n && $stable(rd_data)) else $error("read taken while empty");
	reset_flags_a: assert property (
		!mr |=> flags == 4'b0101) else $error("flags wrong after fifo reset");
	empty_order_a: assert property (
		!empty_indicator_n |-> !almost_empty_indicator_n) else $error("empty without almost empty");
	full_order_a: assert property (
		!full_indicator_n |-> !almost_full_indicator_n) else $error("full without almost full");
	ae_default_a: assert property (
		mode_q && !empty_indicator_n && w8 ##1 w8 [*6] ##1 (w8 && !almost_empty_indicator_n)
		|=> almost_empty_indicator_n) else $error("default empty offset not seven");
	rdata_idle_a: assert property (
		!reg_rd |=> reg_rdata == 16'h0000) else $error("read data outside read slot");
	cover property (w8 && !empty_indicator_n);
	cover property (!full_indicator_n);
	cover property (irq);
endmodule
`default_nettype wire

// ---- verification/sfc_partner.sv ----
`default_nettype none
// ----------------------------------------
// Writer and reader logic at the far side
// ----------------------------------------
module sfc_partner (
	input  wire logic       clk,
	output var  logic       master_reset_n,
	output var  logic [8:0] wr_data,
	output var  logic       wr_gate_n,
	output var  logic       pin,
	output var  logic       rd_gate_n
);
	timeunit 1ns;
	timeprecision 1ps;
	// Idle levels; the fifo reset starts asserted
	initial begin
		master_reset_n = 1'b0;
		wr_data = 9'h000;
		{wr_gate_n, pin, rd_gate_n} = 3'b111;
	end
	// pin level during reset picks the mode, then it is moved
	task automatic reset_fifo(input logic mode);
		@(posedge clk);
		pin <= mode;
		master_reset_n <= 1'b0;
		repeat (2) @(posedge clk);
		master_reset_n <= 1'b1;
		pin <= ~mode;
		@(posedge clk);
		pin <= 1'b1;
		#1;
	endtask
	// words sent whole; a gap makes a slow writer, idle data keeps moving
	task automatic push(input int n, input logic [8:0] base, input logic p, input int gap);
		for (int i = 0; i < n; i++) begin
			@(posedge clk);
			wr_gate_n <= 1'b0;
			pin <= p;
			wr_data <= base + 9'(i);
			repeat (gap) begin
				@(posedge clk);
				wr_gate_n <= 1'b1;
				wr_data <= ~wr_data;
			end
		end
		@(posedge clk);
		wr_gate_n <= 1'b1;
		pin <= 1'b1;
		wr_data <= ~wr_data;
		#1;
	endtask
	// Back-to-back reads, n of them
	task automatic pull(input int n, input logic p);
		@(posedge clk);
		rd_gate_n <= 1'b0;
		pin <= p;
		repeat (n) @(posedge clk);
		rd_gate_n <= 1'b1;
		pin <= 1'b1;
		#1;
	endtask
endmodule
`default_nettype wire

// ---- verification/tb.sv ----
`include "sfc_consts.vh"
`default_nettype none
// ----------------------------------------
// Testbench top
// ----------------------------------------
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk, rst_b, reg_wr, reg_rd, secondary_read_gate_n_n;
	logic [3:0]  reg_addr;
	logic [15:0] reg_wdata, rd_v;
	wire         mrst_n, wgate_n, pin, rgate_n, ef_n, ff_n, ae_n, af_n, irq;
	wire  [8:0]  wdata, rdata, rdata_hi;
	wire         ef_hi_n, ff_hi_n, ae_hi_n, af_hi_n;
	// composite end flags: low while any device shows the condition
	wire         ef_all_n = ef_n & ef_hi_n;
	wire         ff_all_n = ff_n & ff_hi_n;
	wire  [15:0] reg_rdata;
	int          num_errors = 0;
	int          checks_done = 0;
	sfc_partner u_part (.clk(clk), .master_reset_n(mrst_n), .wr_data(wdata),
		.wr_gate_n(wgate_n), .pin(pin), .rd_gate_n(rgate_n));
	// second read gate held active except in t_irq, where it is shut to block reads; otherwise the first gate alone controls reads
	sfc_fifo #(.WIDTH(9), .ADDR_W(6)) DUT (.clk(clk), .rst_b(rst_b), .master_reset_n(mrst_n),
		.wr_data(wdata), .primary_write_gate_n(wgate_n),
		.second_write_gate_or_offset_load(pin), .primary_read_gate_n(rgate_n),
		.secondary_read_gate_n(secondary_read_gate_n_n), .rd_data(rdata), .empty_indicator_n(ef_n),
		.full_indicator_n(ff_n), .almost_empty_indicator_n(ae_n),
		.almost_full_indicator_n(af_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
	// width expansion: second device shares every control in parallel
	sfc_fifo #(.WIDTH(9), .ADDR_W(6)) DUT_hi (.clk(clk), .rst_b(rst_b),
		.master_reset_n(mrst_n), .wr_data(wdata), .primary_write_gate_n(wgate_n),
		.second_write_gate_or_offset_load(pin), .primary_read_gate_n(rgate_n),
		.secondary_read_gate_n(secondary_read_gate_n_n), .rd_data(rdata_hi), .empty_indicator_n(ef_hi_n),
		.full_indicator_n(ff_hi_n), .almost_empty_indicator_n(ae_hi_n),
		.almost_full_indicator_n(af_hi_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(), .irq());
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic reg_w(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		{reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
		@(posedge clk);
		reg_wr <= 1'b0;
		#1;
	endtask
	task automatic reg_r(input logic [3:0] a);
		@(posedge clk);
		{reg_rd, reg_addr} <= {1'b1, a};
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		rd_v = reg_rdata;
	endtask
	// Flag order: empty, full, almost empty, almost full
	task automatic flags(input logic [3:0] e);
		chk({12'h000, ef_n, ff_n, ae_n, af_n}, {12'h000, e});
		// composite end flags, partial flags from one device
		chk({12'h000, ef_all_n, ff_all_n, ae_hi_n, af_hi_n}, {12'h000, e});
	endtask
	task automatic lvl(input logic m, input logic [6:0] c);
		reg_r(`SFC_REG_LEVEL);
		chk(rd_v, {m, 8'h00, c});
	endtask
	task automatic t_default;
		u_part.reset_fifo(1'b1);
		flags(4'b0101);
		lvl(1'b1, 7'd0);
		u_part.push(8, 9'h000, 1'b1, 0);
		flags(4'b1111);
		u_part.pull(2, 1'b1);
		chk({7'h00, rdata}, 16'h0001);
		chk({7'h00, rdata_hi}, 16'h0001);
		lvl(1'b1, 7'd6);
		u_part.push(3, 9'h100, 1'b0, 0);
		lvl(1'b1, 7'd6);
		u_part.push(50, 9'h008, 1'b1, 1);
		flags(4'b1111);
		u_part.push(1, 9'h03a, 1'b1, 0);
		flags(4'b1110);
		u_part.push(8, 9'h03b, 1'b1, 0);
		flags(4'b1010);
		reg_r(`SFC_REG_STATUS);
		// Overflow, almost-full and almost-empty entries all recorded
		chk(rd_v, 16'h000d);
	endtask
	task automatic t_load;
		logic [8:0] ofs [5] = '{9'h003, 9'h000, 9'h002, 9'h000, 9'h005};
		u_part.reset_fifo(1'b0);
		foreach (ofs[i]) u_part.push(1, ofs[i], 1'b0, 0);
		for (int i = 0; i < 4; i++) begin
			u_part.pull(1, 1'b0);
			chk({7'h00, rdata}, {7'h00, ofs[i == 0 ? 4 : i]});
		end
		lvl(1'b0, 7'd0);
		u_part.push(5, 9'h000, 1'b1, 0);
		flags(4'b1101);
		u_part.push(1, 9'h005, 1'b1, 0);
		flags(4'b1111);
		u_part.push(55, 9'h006, 1'b1, 0);
		flags(4'b1111);
		u_part.push(1, 9'h03d, 1'b1, 0);
		flags(4'b1110);
	endtask
	task automatic t_irq;
		u_part.reset_fifo(1'b1);
		reg_w(`SFC_REG_STATUS, 16'h000f);
		u_part.pull(1, 1'b1);
		reg_r(`SFC_REG_STATUS);
		chk(rd_v, 16'h0002);
		chk({15'h0000, irq}, 16'h0000);
		reg_w(`SFC_REG_MASK, 16'h0002);
		chk({15'h0000, irq}, 16'h0001);
		reg_w(`SFC_REG_STATUS, 16'h0002);
		chk({15'h0000, irq}, 16'h0000);
		reg_r(4'hf);
		chk(rd_v, 16'h0000);
		reg_r(`SFC_REG_MASK);
		chk(rd_v, 16'h0002);
		// shut second read gate blocks reads
		@(posedge clk);
		secondary_read_gate_n_n <= 1'b1;
		u_part.push(2, 9'h0a5, 1'b1, 0);
		u_part.pull(1, 1'b1);
		lvl(1'b1, 7'd2);
		chk({7'h00, rdata}, 16'h0000);
		@(posedge clk);
		secondary_read_gate_n_n <= 1'b0;
		u_part.pull(2, 1'b1);
		chk({7'h00, rdata}, 16'h00a6);
		chk({7'h00, rdata_hi}, 16'h00a6);
		lvl(1'b1, 7'd0);
	endtask
	task automatic summarize;
		$display("checks_done=%0d num_errors=%0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	initial begin
		{rst_b, secondary_read_gate_n_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		t_default;
		t_load;
		t_irq;
		summarize;
	end
	// Whole run is well under 1000 cycles
	initial begin
		#100000;
		num_errors++;
		summarize;
	end
endmodule
bind sfc_fifo sfc_fifo_assertions #(.WIDTH(WIDTH)) u_chk (.clk(clk), .rst_b(rst_b),
	.master_reset_n(master_reset_n), .primary_write_gate_n(primary_write_gate_n),
	.second_write_gate_or_offset_load(second_write_gate_or_offset_load),
	.primary_read_gate_n(primary_read_gate_n), .rd_data(rd_data),
	.empty_indicator_n(empty_indicator_n), .full_indicator_n(full_indicator_n),
	.almost_empty_indicator_n(almost_empty_indicator_n),
	.almost_full_indicator_n(almost_full_indicator_n), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .irq(irq));
`default_nettype wire
